// [hw/sar_readout_pkg.sv]
/*
 package for the converter sequencing and serial readout block.
 assumes one 100 mhz core clock; link pins are sampled, not clocked on.
*/
package sar_readout_pkg;
   localparam int          RESULT_W        = 16;
   localparam int          CLK_RATE_HZ     = 100_000_000;
   // sample phase, counted in link clock periods (4.5 to 5.0 allowed)
   localparam int          SAMPLE_FALLS    = 5;
   localparam int          CONV_FALLS      = RESULT_W;
   localparam int          MIN_FRAME_CLKS  = 22;
   localparam int          LINK_MIN_HZ     = 24_000;
   localparam int          LINK_MAX_HZ     = 6_000_000;
   localparam int          LINK_MAX_CYCLES = CLK_RATE_HZ / LINK_MIN_HZ;
   localparam int          LINK_MIN_CYCLES = CLK_RATE_HZ / LINK_MAX_HZ;
   localparam int          FIFO_DEPTH      = 8;
   localparam int          TRIM_W          = 8;
   localparam logic [7:0]  TRIM_RESET      = 8'h00;
   localparam logic [4:0]  CNT_RESET       = 5'h00;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_TRIM   = 3'b011,
      ST_MSB    = 3'b010,
      ST_LSB    = 3'b110,
      ST_ZERO   = 3'b111
   } phase_t;

   typedef struct packed {
      logic dout;
      logic dout_oe;
   } link_out_t;

   typedef struct packed {
      logic [RESULT_W-1:0] code;
   } sample_word_t;
endpackage

// [hw/sar_fifo.sv]
/*
 small synchronous fifo with valid/ready on both sides.
 assumes one clock and an asynchronous active high reset.
*/
`timescale 1ns/10ps
module sar_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_t;

   logic [WIDTH-1:0] mem [DEPTH];
   fifo_state_t      st_reg;
   fifo_state_t      st_next;
   logic             push;
   logic             pop;

   assign in_ready  = (st_reg.wr - st_reg.rd) != (AW+1)'(DEPTH);
   assign out_valid = st_reg.wr != st_reg.rd;
   assign out_data  = mem[st_reg.rd[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[st_reg.wr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// [hw/sar_adc_serial_readout.sv]
/*
 conversion sequencing and serial readout of a 16-bit sar converter.
 assumes the host drives select_shutdown_n and conversion_shift_clock as
 slow pins; both are synchronised into core_clk and falling clock edges are detected.
 the converter core hands results through an 8-word fifo.
*/
// Function
// - sample phase lasts 4.5 to 5 clocks
// - result shifts out msb first
// - output bits belong to current conversion; code sends the fifo head taken at the end of sampling, or zeros if empty
// - then same result again, lsb first
// - afterwards zeros while still selected
// - reload trim after sampling, before approximation
// - low select converts, high select shuts down
// - output bit changes on falling edge
`timescale 1ns/10ps
module sar_adc_serial_readout #(
   parameter int RESULT_W = sar_readout_pkg::RESULT_W,
   parameter int DEPTH    = sar_readout_pkg::FIFO_DEPTH,
   parameter int TRIM_W   = sar_readout_pkg::TRIM_W
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                select_shutdown_n,
   input  wire logic                conversion_shift_clock,
   output logic                     serial_dout,
   output logic                     serial_dout_oe,
   output logic                     sample_hold,
   output logic                     shutdown,
   input  wire logic [RESULT_W-1:0] conv_code,
   input  wire logic                conv_valid,
   output logic                     conv_ready,
   input  wire logic [TRIM_W-1:0]   trim_stored,
   output logic      [TRIM_W-1:0]   trim_active
);
   typedef struct packed {
      logic [1:0]                 sel_sync;
      logic [1:0]                 clk_sync;
      logic                       clk_last;
      sar_readout_pkg::phase_t    phase;
      logic [4:0]                 cnt;
      logic [RESULT_W-1:0]        shreg;
      logic                       dout;
      logic                       dout_oe;
      logic [TRIM_W-1:0]          trim;
      logic                       got_word;
   } state_t;

   state_t                  s_reg;
   state_t                  s_next;
   logic                    sel_low;
   logic                    fall;
   logic [RESULT_W-1:0]     word_data;
   logic                    word_valid;
   logic                    word_take;

   // result words cross from the converter core through the buffer
   sar_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_data   (conv_code),
      .in_valid  (conv_valid),
      .in_ready  (conv_ready),
      .out_data  (word_data),
      .out_valid (word_valid),
      .out_ready (word_take)
   );

   assign sel_low = !s_reg.sel_sync[1];
   assign fall    = s_reg.clk_last && !s_reg.clk_sync[1];
   // stale words are dropped while shut down so no old sample leaks out
   assign word_take = (s_reg.phase == sar_readout_pkg::ST_TRIM && fall && word_valid)
                    || !sel_low;

   always_comb begin
      s_next          = s_reg;
      s_next.sel_sync = {s_reg.sel_sync[0], select_shutdown_n};
      s_next.clk_sync = {s_reg.clk_sync[0], conversion_shift_clock};
      s_next.clk_last = s_reg.clk_sync[1];
      if (!sel_low) begin
         // deselect ends any frame at once
         s_next.phase   = sar_readout_pkg::ST_IDLE;
         s_next.dout_oe = 1'b0;
         s_next.dout    = 1'b0;
         s_next.cnt     = sar_readout_pkg::CNT_RESET;
      end else if (fall) begin
         s_next.dout_oe = 1'b1;
         case (s_reg.phase)
            sar_readout_pkg::ST_IDLE: begin
               s_next.phase = sar_readout_pkg::ST_SAMPLE;
               s_next.cnt   = 5'h01;
               s_next.dout  = 1'b0;
            end
            sar_readout_pkg::ST_SAMPLE: begin
               if (s_reg.cnt == 5'(sar_readout_pkg::SAMPLE_FALLS - 1)) begin
                  s_next.phase = sar_readout_pkg::ST_TRIM;
               end
               s_next.cnt = s_reg.cnt + 5'h01;
            end
            sar_readout_pkg::ST_TRIM: begin
               s_next.trim     = trim_stored;
               s_next.phase    = sar_readout_pkg::ST_MSB;
               s_next.shreg    = word_valid ? word_data : '0;
               s_next.got_word = word_valid;
               s_next.dout     = word_valid ? word_data[RESULT_W-1] : 1'b0;
               s_next.cnt      = 5'h01;
            end
            sar_readout_pkg::ST_MSB: begin
               if (s_reg.cnt == 5'(RESULT_W)) begin
                  // lsb already on the pin; repeat starts at bit 1, one above it
                  s_next.phase = sar_readout_pkg::ST_LSB;
                  s_next.dout  = s_reg.shreg[1];
                  s_next.cnt   = 5'h02;
               end else begin
                  s_next.dout = s_reg.shreg[RESULT_W-1-32'(s_reg.cnt)];
                  s_next.cnt  = s_reg.cnt + 5'h01;
               end
            end
            sar_readout_pkg::ST_LSB: begin
               if (s_reg.cnt == 5'(RESULT_W)) begin
                  s_next.phase = sar_readout_pkg::ST_ZERO;
                  s_next.dout  = 1'b0;
               end else begin
                  s_next.dout = s_reg.shreg[s_reg.cnt[3:0]];
                  s_next.cnt  = s_reg.cnt + 5'h01;
               end
            end
            sar_readout_pkg::ST_ZERO: begin
               s_next.dout = 1'b0;
            end
            default: begin
               s_next.phase = sar_readout_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg          <= '0;
         s_reg.sel_sync <= 2'h3;
         // idle levels, so no false edge follows reset
         s_reg.clk_sync <= 2'h3;
         s_reg.clk_last <= 1'b1;
         s_reg.phase    <= sar_readout_pkg::ST_IDLE;
         s_reg.trim     <= sar_readout_pkg::TRIM_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign serial_dout    = s_reg.dout;
   assign serial_dout_oe = s_reg.dout_oe;
   // trim period is the last of five sampling periods; deselect ends it at once
   assign sample_hold    = sel_low && (s_reg.phase == sar_readout_pkg::ST_SAMPLE
                                       || s_reg.phase == sar_readout_pkg::ST_TRIM);
   assign shutdown       = !sel_low;
   assign trim_active    = s_reg.trim;
endmodule

// [tb/sar_readout_props.sv]
/*
 checker on the readout block pins.
 assumes link half periods of at least 6 core cycles.
*/
`timescale 1ns/10ps
module sar_readout_props #(
   parameter int TRIM_W = 8
) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              select_shutdown_n,
   input wire logic              conversion_shift_clock,
   input wire logic              serial_dout,
   input wire logic              serial_dout_oe,
   input wire logic              sample_hold,
   input wire logic              shutdown,
   input wire logic [TRIM_W-1:0] trim_stored,
   input wire logic [TRIM_W-1:0] trim_active
);
   logic       clk_reg;
   logic [3:0] falls_reg;
   // link falls counted on the raw pin; frames cut by deselect are exempt
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clk_reg   <= 1'b1;
         falls_reg <= 4'h0;
      end else begin
         clk_reg   <= conversion_shift_clock;
         falls_reg <= !sample_hold ? 4'h0 : falls_reg + 4'(clk_reg && !conversion_shift_clock);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_off; select_shutdown_n[*5] |-> !serial_dout_oe; endproperty
   a_off: assert property (p_off) else $error("output driven while deselected");
   property p_shut; select_shutdown_n[*4] |-> shutdown; endproperty
   a_shut: assert property (p_shut) else $error("no shutdown while deselected");
   property p_sel; !select_shutdown_n[*4] |-> !shutdown; endproperty
   a_sel: assert property (p_sel) else $error("shutdown while selected");
   property p_hold; sample_hold |-> !shutdown && !$past(select_shutdown_n, 2); endproperty
   a_hold: assert property (p_hold) else $error("sampling in shutdown");
   property p_len; $fell(sample_hold) && !shutdown |-> falls_reg == 4'h5; endproperty
   a_len: assert property (p_len) else $error("sample phase length wrong");
   property p_edge; $changed(serial_dout) && serial_dout_oe && $past(serial_dout_oe)
      |-> $past(conversion_shift_clock, 6) && !$past(conversion_shift_clock, 3); endproperty
   a_edge: assert property (p_edge) else $error("output bit moved off a falling edge");
   property p_en; $rose(serial_dout_oe) |-> !select_shutdown_n && !conversion_shift_clock;
   endproperty
   a_en: assert property (p_en) else $error("output enabled off a falling edge");
   property p_trim; $changed(trim_active) |-> trim_active == $past(trim_stored) && !shutdown;
   endproperty
   a_trim: assert property (p_trim) else $error("trim reload wrong");
endmodule
bind sar_adc_serial_readout sar_readout_props #(.TRIM_W(TRIM_W)) i_props (
   .core_clk(core_clk), .rst(rst), .select_shutdown_n(select_shutdown_n),
   .conversion_shift_clock(conversion_shift_clock), .serial_dout(serial_dout),
   .serial_dout_oe(serial_dout_oe), .sample_hold(sample_hold), .shutdown(shutdown),
   .trim_stored(trim_stored), .trim_active(trim_active));

// [tb/sar_host_model.sv]
/*
 host model: drives select and link clock, captures on rising edges.
 assumes a 100 mhz core clock; link clock idles high between frames.
*/
`timescale 1ns/10ps
module sar_host_model (
   input  wire logic core_clk,
   input  wire logic serial_dout,
   input  wire logic serial_dout_oe,
   output logic      select_shutdown_n,
   output logic      conversion_shift_clock
);
   // 2.5 mhz, keeps 200 ns high and low times
   localparam int HALF = 20;
   // link clock idles high, device starts deselected
   initial begin
      select_shutdown_n      <= 1'b1;
      conversion_shift_clock <= 1'b1;
   end
   task automatic sel(input logic v);
      repeat (4) @(posedge core_clk);
      select_shutdown_n <= v;
      repeat (2 * HALF) @(posedge core_clk);
   endtask
   task automatic clocks(input int n, output logic [63:0] bits);
      bits = 64'h0;
      @(posedge core_clk);
      for (int k = 1; k <= n; k++) begin
         conversion_shift_clock <= 1'b0;
         repeat (HALF) @(posedge core_clk);
         bits[k] = (serial_dout_oe === 1'b1) ? serial_dout : 1'bx;
         conversion_shift_clock <= 1'b1;
         repeat (HALF) @(posedge core_clk);
      end
   endtask
endmodule

// [tb/test_sar_adc_serial_readout.sv]
/*
 bench for the readout block with the host model on the link pins.
 assumes package, fifo and design compiled first.
*/
`timescale 1ns/10ps
module test_sar_adc_serial_readout;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        sel_n, lclk, dout, oe, hold, shdn, rdy;
   logic        valid;
   logic [15:0] code;
   logic [7:0]  trim;
   logic [7:0]  trim_q;
   logic [63:0] bits;
   int          miscompares = 0;
   int          num_checks = 0;
   always #5 core_clk = ~core_clk;
   sar_adc_serial_readout i_dut (.core_clk(core_clk), .rst(rst), .select_shutdown_n(sel_n),
      .conversion_shift_clock(lclk), .serial_dout(dout), .serial_dout_oe(oe),
      .sample_hold(hold), .shutdown(shdn), .conv_code(code), .conv_valid(valid),
      .conv_ready(rdy), .trim_stored(trim), .trim_active(trim_q));
   sar_host_model i_host (.core_clk(core_clk), .serial_dout(dout), .serial_dout_oe(oe),
      .select_shutdown_n(sel_n), .conversion_shift_clock(lclk));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [63:0] stream(input logic [15:0] c, input int n);
      logic [63:0] s;
      s = 64'h0;
      // msb after five sampling periods; lsb repeat skips bit 0
      for (int k = 6; k <= 21; k++) s[k] = c[21-k];
      for (int k = 22; k <= 36; k++) s[k] = c[k-21];
      return s & ((64'h1 << (n + 1)) - 64'h1);
   endfunction
   task automatic push(input logic [15:0] c);
      @(posedge core_clk);
      code  <= c;
      valid <= 1'b1;
      @(negedge core_clk);
      while (rdy !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
      valid <= 1'b0;
   endtask
   task automatic test_stream;
      trim <= 8'h5a;
      i_host.sel(1'b0);
      check("shutdown", shdn, 1'b0);
      push(16'hb38e);
      i_host.clocks(40, bits);
      check("stream", bits, stream(16'hb38e, 40));
      check("trim", trim_q, 8'h5a);
      i_host.sel(1'b1);
      check("oe", oe, 1'b0);
      check("shutdown", shdn, 1'b1);
      $display("test_stream done");
   endtask
   task automatic test_short;
      logic [15:0] c [2] = '{16'h8001, 16'h7ffe};
      for (int i = 0; i < 2; i++) begin
         trim <= c[i][7:0];
         i_host.sel(1'b0);
         push(c[i]);
         i_host.clocks(22, bits);
         check("short", bits, stream(c[i], 22));
         check("trim", trim_q, c[i][7:0]);
         i_host.sel(1'b1);
      end
      $display("test_short done");
   endtask
   task automatic test_fill;
      i_host.sel(1'b0);
      for (int i = 0; i < 8; i++) push(16'h1000 + 16'(i));
      @(negedge core_clk);
      check("ready full", rdy, 1'b0);
      i_host.clocks(22, bits);
      check("head", bits, stream(16'h1000, 22));
      i_host.sel(1'b1);
      check("ready drained", rdy, 1'b1);
      i_host.sel(1'b0);
      i_host.clocks(22, bits);
      check("empty", bits, 64'h0);
      i_host.sel(1'b1);
      $display("test_fill done");
   endtask
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      valid <= 1'b0;
      code  <= 16'h0000;
      trim  <= 8'h00;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      test_stream;
      test_short;
      test_fill;
      wrap_up;
   end
   // tests need about 5600 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      wrap_up;
   end
endmodule
